// >>> src/sfcu_map.vh
// Constants for the skip and flow control unit.
// Assumes inclusion by the core and by the bench files that use it; definitions only.
`ifndef SFCU_MAP_VH
`define SFCU_MAP_VH

// ----------------------------------------
// Operation codes on i_op
// ----------------------------------------
`define SFCU_OP_W 4
`define SFCU_OP_NONE 4'h0
`define SFCU_OP_TLS_IO 4'h1
`define SFCU_OP_THS_IO 4'h2
`define SFCU_OP_TLS_MEM 4'h3
`define SFCU_OP_THS_MEM 4'h4
`define SFCU_OP_INC_ACC 4'h5
`define SFCU_OP_DEC_ACC 4'h6
`define SFCU_OP_INC_MEM 4'h7
`define SFCU_OP_DEC_MEM 4'h8
`define SFCU_OP_CALL 4'h9
`define SFCU_OP_JUMP 4'hA
`define SFCU_OP_RET_IMM 4'hB
`define SFCU_OP_RET 4'hC
`define SFCU_OP_RETI 4'hD
`define SFCU_OP_PCADD 4'hE

// ----------------------------------------
// Flag vector positions
// ----------------------------------------
`define SFCU_FLAG_Z 0
`define SFCU_FLAG_C 1
`define SFCU_FLAG_AC 2
`define SFCU_FLAG_OV 3

// ----------------------------------------
// Reset values and stack step
// ----------------------------------------
`define SFCU_PC_RST 12'h000
`define SFCU_SP_RST 8'h00
`define SFCU_SP_STEP 8'h02

`endif

// >>> src/sfcu_stack_mem.v
// Stack memory for return addresses, one word per stack slot.
// Assumes the caller addresses it with the byte stack pointer halved.
`timescale 1ns/1ns
module sfcu_stack_mem #(
  parameter AW = 3,
  parameter DW = 12
) (
  // Clock
  input wire i_mclk,
  // Write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  // Read port
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // sfcu_stack_mem

// >>> src/sfcu_core.v
// Skip and flow control unit: executes bit-test skips, inc/dec-and-skip,
// calls, jumps, returns and computed jumps of a small 8-bit core.
// Assumes the fetch logic presents one decoded instruction on i_op with
// i_op_valid, holds it until o_busy falls, and supplies operands.
`timescale 1ns/1ns
`include "sfcu_map.vh"

// Overview of operation
// [RULE1] IO bit test skips next instruction if bit low/high; flags unchanged.
// [RULE2] Memory bit test skips next instruction if bit low/high; flags unchanged.
// [RULE3] Working register increment updates four flags, skips when result zero.
// [RULE4] Working register decrement updates four flags, skips when result zero.
// [RULE5] Memory increment writes byte plus one, updates flags, skips on zero.
// [RULE6] Memory decrement writes byte minus one, updates flags, skips on zero.
// [RULE7] Call stores next address at stack pointer, loads target, pointer plus two.
// [RULE8] Jump loads any program address into the program counter.
// [RULE9] Return with immediate loads the byte into working register, then returns.
// [RULE10] Return lowers stack pointer by two, reloads counter from that slot.
// [RULE11] Interrupt return restores counter and sets global interrupt enable in the same cycle.
// [RULE12] Computed jump adds unsigned working register to the program counter.
// [RULE13] Skips take one cycle when not taken, two cycles when taken.
// [RULE14] Jump, call, computed jump and returns take two cycles.
// [RULE15] A skip discards exactly the next instruction with no side effects.
module sfcu_core #(
  parameter PCW = 12,
  parameter SAW = 3
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_reset,
  // Instruction
  input wire i_op_valid,
  input wire [`SFCU_OP_W-1:0] i_op,
  input wire [2:0] i_bit_sel,
  input wire [PCW-1:0] i_target,
  input wire [7:0] i_imm,
  // Operands
  input wire [7:0] i_io_data,
  input wire [7:0] i_mem_data,
  input wire [7:0] i_acc,
  // Results
  output reg o_busy,
  output reg o_skip,
  output reg [PCW-1:0] o_pc,
  output reg [7:0] o_stack_pointer,
  output reg o_acc_we,
  output reg [7:0] o_acc,
  output reg o_mem_we,
  output reg [7:0] o_mem_wdata,
  output reg o_flags_we,
  output reg [3:0] o_flags,
  output reg o_gie_set
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_EXEC = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RET = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg skip_pend_r;
  reg reti_r;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  function [11:0] sfcu_incdec;
    input [7:0] a;
    input dec;
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] b;
    begin
      b = dec ? 8'hFF : 8'h01;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      // Borrow on decrement is the inverted carry of a + 0xFF
      sfcu_incdec[7:0] = s[7:0];
      sfcu_incdec[8+`SFCU_FLAG_Z] = (s[7:0] == 8'h00);
      sfcu_incdec[8+`SFCU_FLAG_C] = dec ? ~s[8] : s[8];
      sfcu_incdec[8+`SFCU_FLAG_AC] = dec ? ~h[4] : h[4];
      sfcu_incdec[8+`SFCU_FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    end
  endfunction

  wire is_dec = (i_op == `SFCU_OP_DEC_ACC) || (i_op == `SFCU_OP_DEC_MEM);
  wire is_mem = (i_op == `SFCU_OP_INC_MEM) || (i_op == `SFCU_OP_DEC_MEM);
  wire [7:0] arith_in = is_mem ? i_mem_data : i_acc;
  wire [11:0] arith = sfcu_incdec(arith_in, is_dec);
  wire io_bit = i_io_data[i_bit_sel];
  wire mem_bit = i_mem_data[i_bit_sel];
  wire [PCW-1:0] pc_inc = o_pc + {{(PCW-1){1'b0}}, 1'b1};
  wire [PCW-1:0] pc_add = o_pc + {{(PCW-8){1'b0}}, i_acc};

  // ----------------------------------------
  // Stack memory
  // ----------------------------------------
  wire [7:0] sp_dec = o_stack_pointer - `SFCU_SP_STEP;
  wire [PCW-1:0] stack_rdata;
  wire is_ret = (i_op == `SFCU_OP_RET) || (i_op == `SFCU_OP_RET_IMM) ||
    (i_op == `SFCU_OP_RETI);
  wire take = i_op_valid && (state_r == ST_EXEC) && !skip_pend_r;

  sfcu_stack_mem #(
    .AW(SAW),
    .DW(PCW)
  ) u_stack (
    .i_mclk(i_mclk),
    .i_we(take && (i_op == `SFCU_OP_CALL)),
    .i_waddr(o_stack_pointer[SAW:1]),
    .i_wdata(pc_inc),
    .i_raddr(sp_dec[SAW:1]),
    .o_rdata(stack_rdata)
  );

  // ----------------------------------------
  // Skip decision
  // ----------------------------------------
  reg cond;
  always @* begin
    case (i_op)
      `SFCU_OP_TLS_IO: cond = !io_bit; // RULE1
      `SFCU_OP_THS_IO: cond = io_bit; // RULE1
      `SFCU_OP_TLS_MEM: cond = !mem_bit; // RULE2
      `SFCU_OP_THS_MEM: cond = mem_bit; // RULE2
      `SFCU_OP_INC_ACC, `SFCU_OP_DEC_ACC,
      `SFCU_OP_INC_MEM, `SFCU_OP_DEC_MEM: cond = arith[8+`SFCU_FLAG_Z]; // RULE3 RULE4
      default: cond = 1'b0;
    endcase
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC: begin
        if (take) begin
          if (is_ret) begin
            state_nxt = ST_RET;
          end else if (i_op != `SFCU_OP_NONE && (cond || i_op >= `SFCU_OP_CALL)) begin
            state_nxt = ST_WAIT; // RULE13 RULE14
          end
        end
      end
      ST_WAIT: state_nxt = ST_EXEC;
      ST_RET: state_nxt = ST_EXEC;
      default: state_nxt = ST_EXEC;
    endcase
  end

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_EXEC;
      skip_pend_r <= 1'b0;
      reti_r <= 1'b0;
      o_busy <= 1'b0;
      o_skip <= 1'b0;
      o_pc <= `SFCU_PC_RST;
      o_stack_pointer <= `SFCU_SP_RST;
      o_acc_we <= 1'b0;
      o_acc <= 8'h00;
      o_mem_we <= 1'b0;
      o_mem_wdata <= 8'h00;
      o_flags_we <= 1'b0;
      o_flags <= 4'h0;
      o_gie_set <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_busy <= (state_nxt != ST_EXEC);
      o_acc_we <= 1'b0;
      o_mem_we <= 1'b0;
      o_flags_we <= 1'b0;
      o_gie_set <= 1'b0;
      o_skip <= 1'b0;
      if (state_r == ST_RET) begin
        o_pc <= stack_rdata; // RULE10
        o_gie_set <= reti_r; // RULE11
        reti_r <= 1'b0;
      end else if (state_r == ST_EXEC && i_op_valid) begin
        if (skip_pend_r) begin
          // Discarded slot: only the counter moves on
          skip_pend_r <= 1'b0;
          o_pc <= pc_inc; // RULE15
        end else begin
          o_pc <= pc_inc;
          case (i_op)
            `SFCU_OP_TLS_IO, `SFCU_OP_THS_IO,
            `SFCU_OP_TLS_MEM, `SFCU_OP_THS_MEM: begin
              skip_pend_r <= cond; // RULE1 RULE2
              o_skip <= cond;
            end
            `SFCU_OP_INC_ACC, `SFCU_OP_DEC_ACC: begin
              o_acc <= arith[7:0]; // RULE3 RULE4
              o_acc_we <= 1'b1;
              o_flags <= arith[11:8];
              o_flags_we <= 1'b1;
              skip_pend_r <= cond;
              o_skip <= cond;
            end
            `SFCU_OP_INC_MEM, `SFCU_OP_DEC_MEM: begin
              o_mem_wdata <= arith[7:0]; // RULE5 RULE6
              o_mem_we <= 1'b1;
              o_flags <= arith[11:8];
              o_flags_we <= 1'b1;
              skip_pend_r <= cond;
              o_skip <= cond;
            end
            `SFCU_OP_CALL: begin
              o_pc <= i_target; // RULE7
              o_stack_pointer <= o_stack_pointer + `SFCU_SP_STEP; // RULE7
            end
            `SFCU_OP_JUMP: o_pc <= i_target; // RULE8
            `SFCU_OP_RET_IMM, `SFCU_OP_RET, `SFCU_OP_RETI: begin
              if (i_op == `SFCU_OP_RET_IMM) begin
                o_acc <= i_imm; // RULE9
                o_acc_we <= 1'b1;
              end
              o_stack_pointer <= sp_dec; // RULE10
              reti_r <= (i_op == `SFCU_OP_RETI); // RULE11
            end
            `SFCU_OP_PCADD: o_pc <= pc_add; // RULE12
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule // sfcu_core

// >>> testbench/sfcu_core_assertions.sv
// Port checker of the skip and flow control core.
// Assumes it is bound onto sfcu_core and sees only its ports.
`timescale 1ns/1ns
`include "sfcu_map.vh"
module sfcu_core_assertions #(parameter PCW = 12) (
  input wire i_mclk, i_reset, i_op_valid,
  input wire [`SFCU_OP_W-1:0] i_op,
  input wire [2:0] i_bit_sel,
  input wire [PCW-1:0] i_target,
  input wire [7:0] i_imm, i_io_data, i_mem_data, i_acc,
  input wire o_busy, o_skip, o_acc_we, o_mem_we, o_flags_we, o_gie_set,
  input wire [PCW-1:0] o_pc,
  input wire [7:0] o_stack_pointer, o_acc, o_mem_wdata,
  input wire [3:0] o_flags
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // --------------
  // Taken op
  // --------------
  // Slot after a taken skip is discarded, so it is no taken op
  reg skp_r;
  always @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      skp_r <= 1'b0;
    end else if (o_skip) begin
      skp_r <= 1'b1;
    end else if (i_op_valid && !o_busy) begin
      skp_r <= 1'b0;
    end
  end
  wire tk = i_op_valid && !o_busy && !skp_r;
  wire io_b = i_io_data[i_bit_sel];
  wire mem_b = i_mem_data[i_bit_sel];
  property p_flow;
    tk && i_op >= `SFCU_OP_CALL && i_op <= `SFCU_OP_PCADD |=> o_busy ##1 !o_busy; endproperty
  a_flow: assert property (p_flow) else $error("flow op length");
  property p_skip; o_skip |-> o_busy ##1 !o_busy; endproperty
  a_skip: assert property (p_skip) else $error("skip length");
  property p_io; tk && (i_op == `SFCU_OP_TLS_IO || i_op == `SFCU_OP_THS_IO) |=>
    o_skip == ($past(io_b) ^ ($past(i_op) == `SFCU_OP_TLS_IO)) && !o_flags_we; endproperty
  a_io: assert property (p_io) else $error("io bit skip");
  property p_mb; tk && (i_op == `SFCU_OP_TLS_MEM || i_op == `SFCU_OP_THS_MEM) |=>
    o_skip == ($past(mem_b) ^ ($past(i_op) == `SFCU_OP_TLS_MEM)) && !o_flags_we; endproperty
  a_mb: assert property (p_mb) else $error("mem bit skip");
  property p_acc; tk && (i_op == `SFCU_OP_INC_ACC || i_op == `SFCU_OP_DEC_ACC) |=>
    o_acc_we && o_flags_we && o_skip == (o_acc == 8'h00) &&
    o_acc == $past(i_acc) + ($past(i_op) == `SFCU_OP_INC_ACC ? 8'h01 : 8'hFF); endproperty
  a_acc: assert property (p_acc) else $error("acc step");
  property p_mw; tk && (i_op == `SFCU_OP_INC_MEM || i_op == `SFCU_OP_DEC_MEM) |=>
    o_mem_we && o_flags_we && o_skip == (o_mem_wdata == 8'h00) &&
    o_mem_wdata == $past(i_mem_data) + ($past(i_op) == `SFCU_OP_INC_MEM ? 8'h01 : 8'hFF);
  endproperty
  a_mw: assert property (p_mw) else $error("mem step");
  property p_call; tk && i_op == `SFCU_OP_CALL |=> o_pc == $past(i_target) &&
    o_stack_pointer == $past(o_stack_pointer) + 8'h02; endproperty
  a_call: assert property (p_call) else $error("call");
  property p_ret; tk && i_op >= `SFCU_OP_RET_IMM && i_op <= `SFCU_OP_RETI |=>
    o_stack_pointer == $past(o_stack_pointer) - 8'h02; endproperty
  a_ret: assert property (p_ret) else $error("ret pointer");
  property p_ri; tk && i_op == `SFCU_OP_RET_IMM |=> o_acc_we && o_acc == $past(i_imm);
  endproperty
  a_ri: assert property (p_ri) else $error("ret imm");
  property p_gie; tk && i_op == `SFCU_OP_RETI |=> !o_gie_set ##1 o_gie_set; endproperty
  a_gie: assert property (p_gie) else $error("reti enable");
  property p_disc; skp_r && i_op_valid && !o_busy |=> !o_acc_we && !o_mem_we &&
    !o_flags_we && !o_skip && !o_busy && o_pc == $past(o_pc) + 1'b1; endproperty
  a_disc: assert property (p_disc) else $error("discarded slot");
  c_skip: cover property (o_skip);
  c_gie: cover property (o_gie_set);
  c_call: cover property (tk && i_op == `SFCU_OP_CALL);
endmodule // sfcu_core_assertions
bind sfcu_core sfcu_core_assertions #(.PCW(PCW)) u_chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_op_valid(i_op_valid), .i_op(i_op), .i_bit_sel(i_bit_sel), .i_target(i_target),
  .i_imm(i_imm), .i_io_data(i_io_data), .i_mem_data(i_mem_data), .i_acc(i_acc),
  .o_busy(o_busy), .o_skip(o_skip), .o_acc_we(o_acc_we), .o_mem_we(o_mem_we),
  .o_flags_we(o_flags_we), .o_gie_set(o_gie_set), .o_pc(o_pc),
  .o_stack_pointer(o_stack_pointer), .o_acc(o_acc), .o_mem_wdata(o_mem_wdata),
  .o_flags(o_flags));

// >>> testbench/sfcu_mem_model.sv
// Data memory byte and IO register feeding the core's operands.
// Assumes the bench preloads both; memory follows the core's write-back.
`timescale 1ns/1ns
module sfcu_mem_model (
  input wire i_mclk, i_load, i_mem_we,
  input wire [7:0] i_io_val, i_mem_val, i_mem_wdata,
  output reg [7:0] o_io_data, o_mem_data
);
  always @(posedge i_mclk) begin
    if (i_load) begin
      o_io_data <= i_io_val;
      o_mem_data <= i_mem_val;
    end else if (i_mem_we) begin
      o_mem_data <= i_mem_wdata;
    end
  end
endmodule // sfcu_mem_model

// >>> testbench/tb_skip_and_flow_control_unit.sv
// Self-checking bench of the skip and flow control core.
// Assumes the core, its checker and the memory model are compiled first.
`timescale 1ns/1ns
`include "sfcu_map.vh"
module tb_skip_and_flow_control_unit;
  reg i_mclk = 0, i_reset = 1, vld = 0, ld = 0;
  reg [3:0] op = 0;
  reg [2:0] bs = 0;
  reg [11:0] tgt = 0, ra;
  reg [7:0] imm = 0, acc = 0, iov = 0, memv = 0, s;
  wire [7:0] io_d, mem_d, sp, o_acc, wdata;
  wire [11:0] pc;
  wire [3:0] flg;
  wire busy, skip, acc_we, mem_we, flags_we, gie;
  integer num_errors = 0, check_count = 0, n, k;
  reg [7:0] a, r;
  sfcu_core u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_op_valid(vld), .i_op(op),
    .i_bit_sel(bs), .i_target(tgt), .i_imm(imm), .i_io_data(io_d), .i_mem_data(mem_d),
    .i_acc(acc), .o_busy(busy), .o_skip(skip), .o_pc(pc), .o_stack_pointer(sp),
    .o_acc_we(acc_we), .o_acc(o_acc), .o_mem_we(mem_we), .o_mem_wdata(wdata),
    .o_flags_we(flags_we), .o_flags(flg), .o_gie_set(gie));
  sfcu_mem_model u_mem (.i_mclk(i_mclk), .i_load(ld), .i_mem_we(mem_we), .i_io_val(iov),
    .i_mem_val(memv), .i_mem_wdata(wdata), .o_io_data(io_d), .o_mem_data(mem_d));
  initial forever #10 i_mclk = ~i_mclk;
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (num_errors == 0 && check_count > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  // --------------------------
  // One op, valid for one cycle once not busy
  // --------------------------
  task go(input [3:0] o, input [11:0] t);
    begin
      n = 0;
      while (busy !== 1'b0) begin
        @(posedge i_mclk);
        #1;
        n = n + 1;
        if (n > 4) begin
          chk(busy, 0);
          test_done;
        end
      end
      @(posedge i_mclk);
      op <= o;
      tgt <= t;
      imm <= t[7:0];
      vld <= 1'b1;
      @(posedge i_mclk);
      vld <= 1'b0;
      #1;
    end
  endtask
  task load(input [7:0] io, input [7:0] m);
    begin
      @(posedge i_mclk);
      ld <= 1'b1;
      iov <= io;
      memv <= m;
      acc <= m;
      bs <= 3'h5;
      @(posedge i_mclk);
      ld <= 1'b0;
      #1;
    end
  endtask
  task t_bits;
    begin
      for (k = 1; k <= 4; k = k + 1) begin
        load(8'hA5, 8'h5A);
        go(k[3:0], 0);
        chk(skip, k == 2 || k == 3);
        chk({busy, flags_we}, {k == 2 || k == 3, 1'b0});
        ra = pc;
        go(`SFCU_OP_INC_ACC, 0);
        chk({acc_we, flags_we, pc}, {k != 2 && k != 3, k != 2 && k != 3, ra + 12'h001});
      end
    end
  endtask
  task t_arith;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        a = k[2] ? (k[0] ? 8'h80 : 8'h7F) : (k[0] ? 8'h01 : 8'hFF);
        r = k[0] ? a - 8'h01 : a + 8'h01;
        load(8'h00, a);
        go(`SFCU_OP_INC_ACC + k[1:0], 0);
        chk(k[1] ? {mem_we, wdata} : {acc_we, o_acc}, {1'b1, r});
        chk(flg, {a == (k[0] ? 8'h80 : 8'h7F), a[3:0] == (k[0] ? 4'h0 : 4'hF),
          a == (k[0] ? 8'h00 : 8'hFF), r == 8'h00});
        chk({skip, busy}, {r == 8'h00, r == 8'h00});
        if (r == 8'h00) go(`SFCU_OP_NONE, 0);
      end
    end
  endtask
  task t_flow;
    begin
      s = sp;
      ra = pc + 12'h001;
      go(`SFCU_OP_CALL, 12'h7A5);
      chk({busy, flags_we, sp, pc}, {2'b10, s + 8'h02, 12'h7A5});
      go(`SFCU_OP_JUMP, 12'hFFF);
      chk(pc, 12'hFFF);
      go(`SFCU_OP_RET_IMM, 12'h03C);
      chk({acc_we, o_acc}, 9'h13C);
      @(posedge i_mclk);
      #1;
      chk({sp, pc}, {s, ra});
      go(`SFCU_OP_CALL, 12'h155);
      go(`SFCU_OP_RETI, 0);
      chk(gie, 0);
      @(posedge i_mclk);
      #1;
      chk({gie, pc}, {1'b1, ra + 12'h001});
      load(8'h00, 8'hF0);
      ra = pc;
      go(`SFCU_OP_PCADD, 0);
      @(posedge i_mclk);
      #1;
      chk(pc, ra + 12'h0F0);
    end
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    #1;
    chk({pc, sp}, 20'h00000);
    t_bits;
    t_arith;
    t_flow;
    test_done;
  end
endmodule // tb_skip_and_flow_control_unit
